// ### src/asf_core.sv
// alu flag generation, working register and 8x8 multiplier with wishbone access
// assumes: decoder presents one operation per cycle with the addressed file value;
// the register file takes file_data_r when file_we_r is high
//
// Contract
// - flag register is a legal destination of any operation
// - flag-affecting operation on flag register blocks written data for five flags
// - clear-file to flag register zeroes top bits, sets zero, keeps others
// - bit clear/set, swap and moves other than asf_op_move_file leave the five flags untouched
// - flag bits seven to five always read zero
// - negative flag follows result bit seven
// - overflow flag set when signed result flips sign wrongly
// - zero flag set exactly when the result is zero
// - add and subtract put low-nibble carry in nibble carry flag
// - add and subtract put carry out of bit seven in carry flag
// - subtract adds two's complement; carries mean no borrow
// - rotates load nibble carry from source bit four or three
// - rotates load carry with the bit shifted out
// - multiply finishes in one cycle
// - unsigned 8x8 product lands in high and low product bytes
// - multiply changes no flag
// - multiply takes working register and addressed file register
//
// The register addresses and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "asf_cfg.svh"

module asf_core #(
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // operation from the decoder
  input wire logic op_valid,
  input wire asf_pkg::asf_op_e op_code,
  input wire asf_pkg::asf_dest_e op_dest,
  input wire logic [DW-1:0] op_file,
  input wire logic [DW-1:0] op_literal,
  input wire logic [2:0] op_bit,
  // result to the register file
  output logic file_we_r,
  output logic [DW-1:0] file_data_r,
  // architectural state
  output logic [DW-1:0] alu_flags_r,
  output logic [DW-1:0] working_register_r,
  output logic [DW-1:0] product_high_byte_r,
  output logic [DW-1:0] product_low_byte_r,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic [4:0] flag_mask(input asf_pkg::asf_op_e op);
    logic [4:0] m;
    m = `ASF_FM_NONE;
    case (op)
      asf_pkg::asf_op_add_working_file,
      asf_pkg::asf_op_add_literal,
      asf_pkg::asf_op_subtract_working_file,
      asf_pkg::asf_op_subtract_from_literal: m = `ASF_FM_ARITH;
      asf_pkg::asf_op_and,
      asf_pkg::asf_op_ior,
      asf_pkg::asf_op_xor,
      asf_pkg::asf_op_move_file: m = `ASF_FM_LOGIC;
      asf_pkg::asf_op_clear_file: m = `ASF_FM_CLR;
      asf_pkg::asf_op_rotate_right,
      asf_pkg::asf_op_rotate_left: m = `ASF_FM_ROT;
      default: m = `ASF_FM_NONE;
    endcase
    return m;
  endfunction

  function automatic logic uses_literal(input asf_pkg::asf_op_e op);
    return (op == asf_pkg::asf_op_add_literal) ||
           (op == asf_pkg::asf_op_subtract_from_literal) ||
           (op == asf_pkg::asf_op_move_literal);
  endfunction

  function automatic logic is_sub(input asf_pkg::asf_op_e op);
    return (op == asf_pkg::asf_op_subtract_working_file) ||
           (op == asf_pkg::asf_op_subtract_from_literal);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // datapath

  logic [DW-1:0] src_a;
  logic [DW-1:0] add_y;
  logic [DW-1:0] add_sum;
  logic add_c;
  logic add_dc;
  logic add_ov;
  logic [DW-1:0] res;
  logic [4:0] new_flags;
  logic [4:0] fmask;
  logic [2*DW-1:0] product;
  logic is_mul;

  assign src_a = uses_literal(op_code) ? op_literal : op_file;
  // subtraction is addition of the complement with carry in set
  assign add_y = is_sub(op_code) ? ~working_register_r : working_register_r;
  assign fmask = flag_mask(op_code);
  assign is_mul = op_code == asf_pkg::asf_op_multiply_working_by_file;
  assign product = op_file * working_register_r;

  asf_addsub #(
    .WIDTH(DW)
  ) u_addsub (
    .x(src_a),
    .y(add_y),
    .cin(is_sub(op_code)),
    .sum(add_sum),
    .carry(add_c),
    .nib_carry(add_dc),
    .ovf(add_ov)
  );

  always_comb begin
    res = src_a;
    case (op_code)
      asf_pkg::asf_op_add_working_file,
      asf_pkg::asf_op_add_literal,
      asf_pkg::asf_op_subtract_working_file,
      asf_pkg::asf_op_subtract_from_literal: res = add_sum;
      asf_pkg::asf_op_and: res = src_a & working_register_r;
      asf_pkg::asf_op_ior: res = src_a | working_register_r;
      asf_pkg::asf_op_xor: res = src_a ^ working_register_r;
      asf_pkg::asf_op_clear_file: res = '0;
      asf_pkg::asf_op_bit_clear: res = src_a & ~(8'h01 << op_bit);
      asf_pkg::asf_op_bit_set: res = src_a | (8'h01 << op_bit);
      asf_pkg::asf_op_nibble_swap: res = {src_a[3:0], src_a[7:4]};
      asf_pkg::asf_op_working_to_file_move: res = working_register_r;
      asf_pkg::asf_op_rotate_right: res = {alu_flags_r[`ASF_BIT_C], src_a[DW-1:1]};
      asf_pkg::asf_op_rotate_left: res = {src_a[DW-2:0], alu_flags_r[`ASF_BIT_C]};
      default: res = src_a;
    endcase
  end

  always_comb begin
    new_flags[`ASF_BIT_N] = res[DW-1];
    new_flags[`ASF_BIT_OV] = add_ov;
    new_flags[`ASF_BIT_Z] = res == '0;
    new_flags[`ASF_BIT_DC] = add_dc;
    new_flags[`ASF_BIT_C] = add_c;
    if (op_code == asf_pkg::asf_op_rotate_right) begin
      new_flags[`ASF_BIT_DC] = src_a[`ASF_RRF_DC_BIT];
      new_flags[`ASF_BIT_C] = src_a[0];
    end else if (op_code == asf_pkg::asf_op_rotate_left) begin
      new_flags[`ASF_BIT_DC] = src_a[`ASF_RLF_DC_BIT];
      new_flags[`ASF_BIT_C] = src_a[DW-1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave

  logic bus_hit;
  logic bus_wr;
  logic wr_flags;
  logic wr_work;
  logic wr_product_low_byte;
  logic wr_product_high_byte;
  logic [DW-1:0] rd_mux;

  assign bus_hit = wb_cyc_i && wb_stb_i;
  // write lands on the edge that sees ack high
  assign bus_wr = bus_hit && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign wr_flags = bus_wr && (wb_adr_i == `ASF_ADR_FLAGS);
  assign wr_work = bus_wr && (wb_adr_i == `ASF_ADR_WORK);
  assign wr_product_low_byte = bus_wr && (wb_adr_i == `ASF_ADR_PRODUCT_LOW_BYTE);
  assign wr_product_high_byte = bus_wr && (wb_adr_i == `ASF_ADR_PRODUCT_HIGH_BYTE);

  always_comb begin
    if (wb_adr_i == `ASF_ADR_FLAGS) begin
      rd_mux = {3'h0, alu_flags_r[4:0]};
    end else if (wb_adr_i == `ASF_ADR_PRODUCT_LOW_BYTE) begin
      rd_mux = product_low_byte_r;
    end else if (wb_adr_i == `ASF_ADR_PRODUCT_HIGH_BYTE) begin
      rd_mux = product_high_byte_r;
    end else if (wb_adr_i == `ASF_ADR_WORK) begin
      rd_mux = working_register_r;
    end else begin
      rd_mux = '0;
    end
  end

  // unmapped addresses are acked, read zero, and drop writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_hit && !wb_ack_o;
      wb_dat_o <= {24'h00_0000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag register

  logic core_flags;
  assign core_flags = op_valid && ((fmask != `ASF_FM_NONE) ||
                                   (op_dest == asf_pkg::asf_dst_flags && !is_mul));

  // the core's own update beats a bus write in the same cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alu_flags_r <= `ASF_FLAGS_RST;
    end else if (core_flags) begin
      if (fmask == `ASF_FM_NONE) begin
        alu_flags_r <= {3'h0, res[4:0]};
      end else begin
        // written data to flag bits is blocked, unaffected flags kept
        alu_flags_r <= {3'h0, (alu_flags_r[4:0] & ~fmask) | (new_flags & fmask)};
      end
    end else if (wr_flags) begin
      alu_flags_r <= {3'h0, wb_dat_i[4:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // working register

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      working_register_r <= `ASF_WORK_RST;
    end else if (op_valid && !is_mul && op_dest == asf_pkg::asf_dst_working) begin
      working_register_r <= res;
    end else if (wr_work) begin
      working_register_r <= wb_dat_i[DW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // product register pair

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      product_high_byte_r <= `ASF_PROD_RST;
      product_low_byte_r <= `ASF_PROD_RST;
    end else if (op_valid && is_mul) begin
      product_high_byte_r <= product[2*DW-1:DW];
      product_low_byte_r <= product[DW-1:0];
    end else begin
      if (op_valid && op_dest == asf_pkg::asf_dst_prod_high) begin
        product_high_byte_r <= res;
      end else if (wr_product_high_byte) begin
        product_high_byte_r <= wb_dat_i[DW-1:0];
      end
      if (op_valid && op_dest == asf_pkg::asf_dst_prod_low) begin
        product_low_byte_r <= res;
      end else if (wr_product_low_byte) begin
        product_low_byte_r <= wb_dat_i[DW-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // file result port

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      file_we_r <= 1'b0;
      file_data_r <= '0;
    end else begin
      file_we_r <= op_valid && !is_mul && op_dest == asf_pkg::asf_dst_file;
      file_data_r <= res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  logic op_add_w;
  logic op_sub_lit;
  logic op_keep;
  assign op_add_w = op_valid && op_dest == asf_pkg::asf_dst_working &&
                    op_code == asf_pkg::asf_op_add_literal;
  assign op_sub_lit = op_valid && op_dest == asf_pkg::asf_dst_working &&
                      op_code == asf_pkg::asf_op_subtract_from_literal;
  assign op_keep = op_valid && op_dest == asf_pkg::asf_dst_flags &&
                   (op_code == asf_pkg::asf_op_bit_clear ||
                    op_code == asf_pkg::asf_op_bit_set ||
                    op_code == asf_pkg::asf_op_nibble_swap ||
                    op_code == asf_pkg::asf_op_file_to_file_move ||
                    op_code == asf_pkg::asf_op_working_to_file_move);

  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence bus_ack_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  sequence prod_quiet_s;
    !(op_valid && (is_mul || op_dest == asf_pkg::asf_dst_prod_low ||
                   op_dest == asf_pkg::asf_dst_prod_high)) && !wr_product_low_byte && !wr_product_high_byte;
  endsequence

  upper_zero_a: assert property (alu_flags_r[7:5] == 3'h0)
    else $error("flag bits 7..5 not zero");
  neg_follows_a: assert property (op_add_w |=>
      alu_flags_r[`ASF_BIT_N] == working_register_r[7])
    else $error("negative flag does not follow result msb");
  zero_flag_a: assert property (op_valid && op_dest == asf_pkg::asf_dst_working &&
      op_code == asf_pkg::asf_op_xor |=>
      alu_flags_r[`ASF_BIT_Z] == (working_register_r == 8'h00))
    else $error("zero flag mismatch");
  add_carry_a: assert property (op_add_w |=>
      {alu_flags_r[`ASF_BIT_C], working_register_r} ==
      {1'b0, $past(op_literal)} + {1'b0, $past(working_register_r)})
    else $error("add carry or sum wrong");
  add_nibble_a: assert property (op_add_w |=> alu_flags_r[`ASF_BIT_DC] ==
      (({1'b0, $past(op_literal[3:0])} + {1'b0, $past(working_register_r[3:0])}) > 5'h0F))
    else $error("nibble carry wrong");
  add_overflow_a: assert property (op_add_w |=> alu_flags_r[`ASF_BIT_OV] ==
      (($past(op_literal[7]) == $past(working_register_r[7])) &&
       (working_register_r[7] != $past(op_literal[7]))))
    else $error("overflow flag wrong");
  sub_borrow_a: assert property (op_sub_lit |=> alu_flags_r[`ASF_BIT_C] ==
      ($past(op_literal) >= $past(working_register_r)))
    else $error("borrow polarity wrong");
  rotate_right_a: assert property (
      op_valid && op_code == asf_pkg::asf_op_rotate_right &&
      op_dest != asf_pkg::asf_dst_flags |=>
      alu_flags_r[`ASF_BIT_C] == $past(src_a[0]) &&
      alu_flags_r[`ASF_BIT_DC] == $past(src_a[`ASF_RRF_DC_BIT]))
    else $error("rotate right flags wrong");
  mul_product_a: assert property (op_valid && is_mul |=>
      {product_high_byte_r, product_low_byte_r} ==
      $past(op_file) * $past(working_register_r))
    else $error("product wrong or late");
  mul_flags_a: assert property (op_valid && is_mul && !wr_flags |=> $stable(alu_flags_r))
    else $error("multiply changed flags");
  clear_flags_a: assert property (op_valid && op_code == asf_pkg::asf_op_clear_file &&
      op_dest == asf_pkg::asf_dst_flags |=>
      alu_flags_r == {3'h0, $past(alu_flags_r[4:3]), 1'b1, $past(alu_flags_r[1:0])})
    else $error("clear of flag register wrong");
  keep_write_a: assert property (op_keep |=> alu_flags_r[4:0] == $past(res[4:0]))
    else $error("flag write by non-flag op lost");
  prod_hold_a: assert property (prod_quiet_s |=> $stable(product_high_byte_r) &&
      $stable(product_low_byte_r))
    else $error("product changed without cause");
  bus_answer_a: assert property (bus_req_s |=> bus_ack_s)
    else $error("wishbone ack not one cycle");

endmodule

// ### src/asf_cfg.svh
// constants for the alu flag and multiplier block
// assumes: included by every design file of the block except the package
`ifndef ASF_CFG_SVH
`define ASF_CFG_SVH

// wishbone byte addresses, one aligned word each
`define ASF_ADR_FLAGS 8'h00
`define ASF_ADR_PRODUCT_LOW_BYTE 8'h04
`define ASF_ADR_PRODUCT_HIGH_BYTE 8'h08
`define ASF_ADR_WORK 8'h0C

// flag register bit positions
`define ASF_BIT_N 4
`define ASF_BIT_OV 3
`define ASF_BIT_Z 2
`define ASF_BIT_DC 1
`define ASF_BIT_C 0

// flags touched by each class of operation, bits 4..0
`define ASF_FM_NONE 5'h00
`define ASF_FM_ARITH 5'h1F
`define ASF_FM_LOGIC 5'h14
`define ASF_FM_CLR 5'h04
`define ASF_FM_ROT 5'h17

// rotate nibble-carry source bits
`define ASF_RRF_DC_BIT 4
`define ASF_RLF_DC_BIT 3

// reset values and widths
`define ASF_FLAGS_RST 8'h00
`define ASF_PROD_RST 8'h00
`define ASF_WORK_RST 8'h00
`define ASF_NIB_W 4

`endif

// ### src/asf_pkg.sv
// types shared by the alu flag and multiplier block
// assumes: nothing beyond the cfg header
package asf_pkg;

  typedef enum logic [4:0] {
    asf_op_nop = 5'h00,
    asf_op_add_working_file = 5'h01,
    asf_op_add_literal = 5'h02,
    asf_op_subtract_working_file = 5'h03,
    asf_op_subtract_from_literal = 5'h04,
    asf_op_and = 5'h05,
    asf_op_ior = 5'h06,
    asf_op_xor = 5'h07,
    asf_op_move_file = 5'h08,
    asf_op_clear_file = 5'h09,
    asf_op_bit_clear = 5'h0A,
    asf_op_bit_set = 5'h0B,
    asf_op_nibble_swap = 5'h0C,
    asf_op_file_to_file_move = 5'h0D,
    asf_op_working_to_file_move = 5'h0E,
    asf_op_rotate_right = 5'h0F,
    asf_op_rotate_left = 5'h10,
    asf_op_multiply_working_by_file = 5'h11,
    asf_op_move_literal = 5'h12
  } asf_op_e;

  typedef enum logic [2:0] {
    asf_dst_working = 3'h0,
    asf_dst_file = 3'h1,
    asf_dst_flags = 3'h2,
    asf_dst_prod_low = 3'h3,
    asf_dst_prod_high = 3'h4
  } asf_dest_e;

endpackage

// ### src/asf_addsub.sv
// 8-bit adder with carry, nibble carry and signed overflow
// assumes: subtraction is fed as x + ~y with carry in set
`timescale 1ns/1ps
`include "asf_cfg.svh"

module asf_addsub #(
  parameter int WIDTH = 8
) (
  // operands
  input wire logic [WIDTH-1:0] x,
  input wire logic [WIDTH-1:0] y,
  input wire logic cin,
  // results
  output logic [WIDTH-1:0] sum,
  output logic carry,
  output logic nib_carry,
  output logic ovf
);
  localparam int NIB = `ASF_NIB_W;
  logic [WIDTH:0] full;
  logic [NIB:0] low;

  assign full = {1'b0, x} + {1'b0, y} + {{WIDTH{1'b0}}, cin};
  assign low = {1'b0, x[NIB-1:0]} + {1'b0, y[NIB-1:0]} + {{NIB{1'b0}}, cin};
  assign sum = full[WIDTH-1:0];
  assign carry = full[WIDTH];
  assign nib_carry = low[NIB];
  // sign flips although both operands share a sign
  assign ovf = (x[WIDTH-1] == y[WIDTH-1]) && (full[WIDTH-1] != x[WIDTH-1]);
endmodule

// ### tb/testbench.sv
// self-checking bench for the alu flag and multiplier core
// assumes: asf_core with wishbone slave acking one cycle after a request
`timescale 1ns/1ps
`include "asf_cfg.svh"

`define TB_CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end

module testbench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  asf_pkg::asf_op_e op_code = asf_pkg::asf_op_nop;
  asf_pkg::asf_dest_e op_dest = asf_pkg::asf_dst_working;
  logic [7:0] op_file = 8'h00;
  logic [7:0] op_literal = 8'h00;
  logic [2:0] op_bit = 3'h0;
  logic file_we_r;
  logic [7:0] file_data_r;
  logic [7:0] alu_flags_r;
  logic [7:0] working_register_r;
  logic [7:0] product_high_byte_r;
  logic [7:0] product_low_byte_r;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic [31:0] rd;
  asf_pkg::asf_op_e keep_ops [5];
  logic [7:0] keep_in [5];
  logic [7:0] keep_out [5];

  asf_core #(.DW(8)) i_dut (
    .clock(clock), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .op_dest(op_dest),
    .op_file(op_file), .op_literal(op_literal), .op_bit(op_bit),
    .file_we_r(file_we_r), .file_data_r(file_data_r),
    .alu_flags_r(alu_flags_r), .working_register_r(working_register_r),
    .product_high_byte_r(product_high_byte_r), .product_low_byte_r(product_low_byte_r),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
  );

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 125 cycles the tests need
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end

  // ack is registered, so the value read right after the edge is the sampled one
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] dat);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= {24'h000000, dat};
    // only the hang guard ends a wait that never sees ack
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wb_write(input logic [7:0] adr, input logic [7:0] dat);
    wb_cycle(1'b1, adr, dat);
  endtask

  task automatic wb_read(input logic [7:0] adr);
    wb_cycle(1'b0, adr, 8'h00);
  endtask

  // one op taken at the next edge; returns once its result is visible
  task automatic do_op(input asf_pkg::asf_op_e op, input asf_pkg::asf_dest_e dst,
                       input logic [7:0] fv, input logic [7:0] lit, input logic [2:0] b);
    @(posedge clock);
    op_valid <= 1'b1;
    op_code <= op;
    op_dest <= dst;
    op_file <= fv;
    op_literal <= lit;
    op_bit <= b;
    @(posedge clock);
    op_valid <= 1'b0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    keep_ops[0] = asf_pkg::asf_op_bit_clear;
    keep_ops[1] = asf_pkg::asf_op_bit_set;
    keep_ops[2] = asf_pkg::asf_op_nibble_swap;
    keep_ops[3] = asf_pkg::asf_op_file_to_file_move;
    keep_ops[4] = asf_pkg::asf_op_working_to_file_move;
    keep_in[0] = 8'hFF; keep_out[0] = 8'hF7;
    keep_in[1] = 8'h00; keep_out[1] = 8'h08;
    keep_in[2] = 8'hA5; keep_out[2] = 8'h5A;
    keep_in[3] = 8'h3C; keep_out[3] = 8'h3C;
    keep_in[4] = 8'h11; keep_out[4] = 8'h03;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    wb_read(`ASF_ADR_FLAGS); `TB_CHK("flags rst", 32'h00000000, rd)
    wb_read(`ASF_ADR_PRODUCT_HIGH_BYTE); `TB_CHK("product_high_byte rst", 32'h00000000, rd)
    wb_read(8'h10); `TB_CHK("unmapped", 32'h00000000, rd)
    wb_write(`ASF_ADR_FLAGS, 8'hFF);
    wb_read(`ASF_ADR_FLAGS); `TB_CHK("flags top", 32'h0000001F, rd)
    // signed overflow with nibble carry, then wrap to zero
    wb_write(`ASF_ADR_WORK, 8'h7F);
    do_op(asf_pkg::asf_op_add_literal, asf_pkg::asf_dst_working, 8'h00, 8'h01, 3'h0);
    `TB_CHK("add w", 8'h80, working_register_r)
    `TB_CHK("add flags", 8'h1A, alu_flags_r)
    do_op(asf_pkg::asf_op_add_literal, asf_pkg::asf_dst_working, 8'h00, 8'h80, 3'h0);
    `TB_CHK("wrap flags", 8'h0D, alu_flags_r)
    // subtraction: no borrow, then borrow into the file
    wb_write(`ASF_ADR_WORK, 8'h03);
    do_op(asf_pkg::asf_op_subtract_from_literal, asf_pkg::asf_dst_working, 8'h00, 8'h05,
          3'h0);
    `TB_CHK("sublit w", 8'h02, working_register_r)
    `TB_CHK("sublit flags", 8'h03, alu_flags_r)
    do_op(asf_pkg::asf_op_subtract_working_file, asf_pkg::asf_dst_file, 8'h01, 8'h00, 3'h0);
    `TB_CHK("subtract_working_file_instr we", 1'b1, file_we_r)
    `TB_CHK("subtract_working_file_instr data", 8'hFF, file_data_r)
    `TB_CHK("subtract_working_file_instr flags", 8'h10, alu_flags_r)
    // flag register as destination of a flag-affecting op
    wb_write(`ASF_ADR_WORK, 8'h03);
    wb_write(`ASF_ADR_FLAGS, 8'h1F);
    do_op(asf_pkg::asf_op_add_literal, asf_pkg::asf_dst_flags, 8'h1F, 8'h10, 3'h0);
    `TB_CHK("blocked", 8'h00, alu_flags_r)
    wb_write(`ASF_ADR_FLAGS, 8'h13);
    do_op(asf_pkg::asf_op_clear_file, asf_pkg::asf_dst_flags, 8'h13, 8'h00, 3'h0);
    wb_read(`ASF_ADR_FLAGS); `TB_CHK("clear flags", 32'h00000017, rd)
    // flag-neutral ops, back to the file
    wb_write(`ASF_ADR_FLAGS, 8'h15);
    for (int i = 0; i < 5; i++) begin
      do_op(keep_ops[i], asf_pkg::asf_dst_file, keep_in[i], 8'h00, 3'h3);
      `TB_CHK("keep data", keep_out[i], file_data_r)
      `TB_CHK("keep flags", 8'h15, alu_flags_r)
    end
    do_op(asf_pkg::asf_op_bit_set, asf_pkg::asf_dst_flags, 8'h15, 8'h00, 3'h1);
    wb_read(`ASF_ADR_FLAGS); `TB_CHK("bitset flags", 32'h00000017, rd)
    // rotates through carry
    wb_write(`ASF_ADR_FLAGS, 8'h01);
    do_op(asf_pkg::asf_op_rotate_right, asf_pkg::asf_dst_working, 8'h10, 8'h00, 3'h0);
    `TB_CHK("rrf w", 8'h88, working_register_r)
    `TB_CHK("rrf flags", 8'h12, alu_flags_r)
    do_op(asf_pkg::asf_op_rotate_left, asf_pkg::asf_dst_working, 8'h88, 8'h00, 3'h0);
    `TB_CHK("rlf w", 8'h10, working_register_r)
    `TB_CHK("rlf flags", 8'h03, alu_flags_r)
    // multiply in one op cycle, flags untouched, product holds
    wb_write(`ASF_ADR_WORK, 8'hFF);
    wb_write(`ASF_ADR_FLAGS, 8'h0A);
    do_op(asf_pkg::asf_op_multiply_working_by_file, asf_pkg::asf_dst_working, 8'hFE, 8'h00,
          3'h0);
    `TB_CHK("product_high_byte", 8'hFD, product_high_byte_r)
    `TB_CHK("product_low_byte", 8'h02, product_low_byte_r)
    `TB_CHK("mul flags", 8'h0A, alu_flags_r)
    `TB_CHK("mul w", 8'hFF, working_register_r)
    do_op(asf_pkg::asf_op_add_literal, asf_pkg::asf_dst_working, 8'h00, 8'h01, 3'h0);
    wb_read(`ASF_ADR_PRODUCT_LOW_BYTE); `TB_CHK("product_low_byte hold", 32'h00000002, rd)
    wb_write(`ASF_ADR_PRODUCT_HIGH_BYTE, 8'h5C);
    wb_read(`ASF_ADR_PRODUCT_HIGH_BYTE); `TB_CHK("product_high_byte write", 32'h0000005C, rd)
    // logic ops touch only negative and zero, also into a product byte
    do_op(asf_pkg::asf_op_xor, asf_pkg::asf_dst_working, 8'h5A, 8'h00, 3'h0);
    `TB_CHK("xor w", 8'h5A, working_register_r)
    `TB_CHK("xor flags", 8'h03, alu_flags_r)
    do_op(asf_pkg::asf_op_xor, asf_pkg::asf_dst_working, 8'h5A, 8'h00, 3'h0);
    `TB_CHK("xor zero", 8'h07, alu_flags_r)
    do_op(asf_pkg::asf_op_ior, asf_pkg::asf_dst_prod_low, 8'hC3, 8'h00, 3'h0);
    `TB_CHK("ior product_low_byte", 8'hC3, product_low_byte_r)
    `TB_CHK("ior flags", 8'h13, alu_flags_r)
    // mid-run reset clears state at once, bus usable right after release
    @(posedge clock);
    rst_n <= 1'b0;
    #1;
    `TB_CHK("rst w", 8'h00, working_register_r)
    `TB_CHK("rst product_low_byte", 8'h00, product_low_byte_r)
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wb_read(`ASF_ADR_FLAGS); `TB_CHK("rst flags", 32'h00000000, rd)
    print_verdict();
  end
endmodule
